// >>> verilog/dbwm_pkg.sv
// Package with widths, byte layout and burst constants for the byte-masked write path.
package dbwm_pkg;
  localparam int unsigned BYTE_W = 9;
  localparam int unsigned LANES_X18 = 2;
  localparam int unsigned LANES_X36 = 4;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam logic BEAT_FIRST = 1'b0;
  localparam logic BEAT_SECOND = 1'b1;
  typedef enum logic [1:0] {
    DBWM_IDLE = 2'b00,
    DBWM_BEAT1 = 2'b01,
    DBWM_BEAT2 = 2'b10
  } dbwm_state_t;
endpackage

// >>> verilog/dbwm_fifo.sv
// Small synchronous FIFO holding captured write beats ahead of the array.
`timescale 1ns/1ps
module dbwm_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Fill side.
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side.
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int unsigned PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;

  // Flags follow the occupancy count, so full and empty are exact.
  assign in_ready_o = (count != (PW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rd_ptr];

  // Storage is written only on an accepted push.
  always_ff @(posedge clk_sys_i)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // Pointers wrap at the depth, which need not be a power of two.
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
      end
      if (pop)
      begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
      end
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

// >>> verilog/dbwm_core.sv
// Write path of a two-beat burst memory with per-beat byte-lane masking.
// Notes on behaviour
// RULE1 - Narrow build: both selects low write all.
// RULE2 - Narrow build: select 0 only writes low byte.
// RULE3 - Narrow build: select 1 only writes high byte.
// RULE4 - Narrow build: both selects high write nothing.
// RULE5 - Wide build: all selects low write all.
// RULE6 - Wide build: select 0 writes byte 0 only.
// RULE7 - Wide build: select 1 writes byte 1 only.
// RULE8 - Wide build: select 2 writes byte 2 only.
// RULE9 - Wide build: select 3 writes byte 3 only.
// RULE10 - Wide build: all selects high write nothing.
// RULE11 - Each beat applies its own select pattern.
// RULE12 - Controller starts write with load and select low.
// RULE13 - Beats follow address on next edge pair.
// RULE14 - Selects sampled together with each data beat.
// RULE15 - Build parameter picks two or four lanes.
`timescale 1ns/1ps
module dbwm_core #(
  parameter int unsigned LANES = dbwm_pkg::LANES_X18,
  parameter int unsigned ADDR_W = dbwm_pkg::ADDR_W,
  parameter int unsigned FIFO_DEPTH = dbwm_pkg::FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Edge enables standing for positive and negative input clock rises.
  input wire logic pos_edge_en_i,
  input wire logic neg_edge_en_i,
  // Command inputs from the controller.
  input wire logic load_strobe_n_i,
  input wire logic read_write_sel_i,
  input wire logic [ADDR_W-1:0] addr_i,
  // Write data and byte lane selects.
  input wire logic [LANES*dbwm_pkg::BYTE_W-1:0] wr_data_i,
  input wire logic [LANES-1:0] byte_lane_write_select_n_i,
  // Read port of the array.
  input wire logic [ADDR_W-1:0] rd_addr_i,
  output logic [LANES*dbwm_pkg::BYTE_W-1:0] rd_data_o,
  // Status.
  output logic beat_ready_o,
  output logic write_busy_o
);
  localparam int unsigned DW = LANES * dbwm_pkg::BYTE_W;
  localparam int unsigned FW = ADDR_W + LANES + DW;
  localparam int unsigned WORDS = 1 << ADDR_W;

  // Either build is legal; anything else is a configuration error.
  if (LANES != dbwm_pkg::LANES_X18 && LANES != dbwm_pkg::LANES_X36)
  begin : g_bad_lanes
    $error("Byte lane count must be two or four.");
  end

  // Expand active-low lane selects into a per-bit write enable.
  function automatic logic [DW-1:0] lane_mask(input logic [LANES-1:0] sel_n);
    logic [DW-1:0] m;
    m = '0;
    for (int i = 0; i < LANES; i++)
    begin
      m[i*dbwm_pkg::BYTE_W +: dbwm_pkg::BYTE_W] = {dbwm_pkg::BYTE_W{~sel_n[i]}};
    end
    return m;
  endfunction

  dbwm_pkg::dbwm_state_t state;
  dbwm_pkg::dbwm_state_t next_state;
  logic [ADDR_W-1:0] base_addr;
  logic [DW-1:0] array_mem [WORDS];
  logic [FW-1:0] beat_word;
  logic beat_valid;
  logic fifo_ready;
  logic drain_valid;
  logic [FW-1:0] drain_word;
  logic busy;
  logic [LANES-1:0] drain_sel_n;
  logic [ADDR_W-1:0] drain_addr;
  logic [DW-1:0] drain_data;
  logic [DW-1:0] drain_mask;

  // A write starts at a positive edge with load and write select both low.
  wire write_start = pos_edge_en_i && !load_strobe_n_i && !read_write_sel_i; // RULE12
  // Beat one lands on the next positive edge, beat two on the negative edge after.
  wire take_first = (state == dbwm_pkg::DBWM_BEAT1) && pos_edge_en_i; // RULE13
  wire take_second = (state == dbwm_pkg::DBWM_BEAT2) && neg_edge_en_i; // RULE13
  // The burst counter flips the low address bit for the second word.
  wire [ADDR_W-1:0] beat_addr = take_second ? (base_addr ^ ADDR_W'(1)) : base_addr;

  // Each captured beat carries the selects seen with it, not the burst's first.
  assign beat_valid = take_first || take_second;
  assign beat_word = {beat_addr, byte_lane_write_select_n_i, wr_data_i}; // RULE14 RULE11

  // Sequencer: starts are taken from idle only, so a pending burst is never overwritten.
  always_comb
  begin
    next_state = state;
    case (state)
      dbwm_pkg::DBWM_IDLE:
        if (write_start) next_state = dbwm_pkg::DBWM_BEAT1;
      dbwm_pkg::DBWM_BEAT1:
        if (take_first) next_state = dbwm_pkg::DBWM_BEAT2;
      dbwm_pkg::DBWM_BEAT2:
        if (take_second) next_state = dbwm_pkg::DBWM_IDLE;
      default:
        next_state = dbwm_pkg::DBWM_IDLE;
    endcase
  end

  // State and base address; only the pending burst's address is kept.
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      state <= dbwm_pkg::DBWM_IDLE;
      base_addr <= '0;
    end
    else
    begin
      state <= next_state;
      if (write_start && state == dbwm_pkg::DBWM_IDLE)
      begin
        base_addr <= addr_i;
      end
    end
  end

  // Beats queue here so the array write is decoupled from the input edges.
  dbwm_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(beat_valid),
    .in_ready_o(fifo_ready),
    .in_data_i(beat_word),
    .out_valid_o(drain_valid),
    .out_ready_i(1'b1),
    .out_data_o(drain_word)
  );

  // Split the queued beat back into its fields.
  assign drain_data = drain_word[DW-1:0];
  assign drain_sel_n = drain_word[DW +: LANES];
  assign drain_addr = drain_word[FW-1 -: ADDR_W];
  assign drain_mask = lane_mask(drain_sel_n); // RULE15
  assign busy = drain_valid || (state != dbwm_pkg::DBWM_IDLE);

  // Masked merge: unselected lanes keep the stored word, an all-high pattern changes nothing.
  always_ff @(posedge clk_sys_i)
  begin
    if (drain_valid)
    begin
      array_mem[drain_addr] <= (drain_data & drain_mask) |
                               (array_mem[drain_addr] & ~drain_mask); // RULE1 RULE2 RULE3 RULE4 RULE5 RULE6 RULE7 RULE8 RULE9 RULE10
    end
  end

  // Registered read port and status outputs.
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      rd_data_o <= '0;
      beat_ready_o <= 1'b0;
      write_busy_o <= 1'b0;
    end
    else
    begin
      rd_data_o <= array_mem[rd_addr_i];
      beat_ready_o <= fifo_ready;
      write_busy_o <= busy;
    end
  end

  // A selected low lane takes the new data after the drain.
  chk_lane_written: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE2
    drain_valid && !drain_sel_n[0] |=> array_mem[$past(drain_addr)][dbwm_pkg::BYTE_W-1:0] ==
      $past(drain_data[dbwm_pkg::BYTE_W-1:0]))
    else $error("Selected lane was not written.");

  // An unselected top lane keeps its old contents.
  chk_lane_kept: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE3
    drain_valid && drain_sel_n[LANES-1] |=> array_mem[$past(drain_addr)][DW-1 -: dbwm_pkg::BYTE_W] ==
      $past(array_mem[drain_addr][DW-1 -: dbwm_pkg::BYTE_W]))
    else $error("Unselected lane was altered.");

  // All selects high leave the word untouched.
  chk_no_write: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE4
    drain_valid && &drain_sel_n |=> array_mem[$past(drain_addr)] == $past(array_mem[drain_addr]))
    else $error("Masked beat changed the array.");

  // All selects low write the whole word.
  chk_full_write: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE1
    drain_valid && drain_sel_n == '0 |=> array_mem[$past(drain_addr)] == $past(drain_data))
    else $error("Full write lost data.");

  // The first beat reaches the merge stage addressed at the burst's start word.
  chk_first_beat: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE13
    take_first |=> drain_valid && drain_addr == $past(base_addr))
    else $error("First beat taken out of order.");

  // The second beat reaches the merge stage addressed at the partner word.
  chk_second_addr: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE13
    take_second |=> drain_valid && drain_addr == ($past(base_addr) ^ ADDR_W'(1)))
    else $error("Second beat at wrong address.");

  // Each queued beat arrives with the data and selects present at its own edge.
  chk_own_mask: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE14
    beat_valid |=> drain_sel_n == $past(byte_lane_write_select_n_i) &&
      drain_data == $past(wr_data_i))
    else $error("Beat mask not sampled with data.");

  // Mask expansion matches the lane count.
  chk_mask_width: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE15
    drain_valid |-> $countones(drain_mask) ==
      dbwm_pkg::BYTE_W * (LANES - $countones(drain_sel_n)))
    else $error("Lane mask width wrong.");
endmodule

// >>> tb/dbwm_ctrl_model.sv
// Controller model that issues two-beat write bursts with per-beat lane selects.
`timescale 1ns/1ps
module dbwm_ctrl_model (
  // Clock.
  input wire logic clk_sys_i,
  // Commands and beats.
  output logic pos_edge_en_o,
  output logic neg_edge_en_o,
  output logic load_strobe_n_o,
  output logic read_write_sel_o,
  output logic [3:0] addr_o,
  output logic [35:0] wr_data_o,
  output logic [3:0] byte_lane_write_select_n_o
);
  // Idle lines toggle so that a stale beat never looks valid.
  task automatic idle();
  begin
    pos_edge_en_o = 1'b0;
    neg_edge_en_o = 1'b0;
    load_strobe_n_o = 1'b1;
    read_write_sel_o = 1'b1;
    addr_o = ~addr_o;
    wr_data_o = ~wr_data_o;
    byte_lane_write_select_n_o = ~byte_lane_write_select_n_o;
  end
  endtask
  // One burst: start, positive beat, negative beat, with gap idle cycles between.
  task automatic burst(input logic [3:0] a, input logic [35:0] d1, input logic [35:0] d2,
                       input logic [3:0] s1, input logic [3:0] s2, input logic rd, input int gap);
  begin
    @(negedge clk_sys_i);
    pos_edge_en_o = 1'b1;
    load_strobe_n_o = 1'b0;
    read_write_sel_o = rd;
    addr_o = a;
    @(negedge clk_sys_i);
    load_strobe_n_o = 1'b1;
    wr_data_o = d1;
    byte_lane_write_select_n_o = s1;
    // With no gap the start pulse simply stays up for the first beat.
    if (gap > 0)
    begin
      pos_edge_en_o = 1'b0;
      repeat (gap) @(negedge clk_sys_i);
      pos_edge_en_o = 1'b1;
    end
    @(negedge clk_sys_i);
    pos_edge_en_o = 1'b0;
    wr_data_o = d2;
    byte_lane_write_select_n_o = s2;
    repeat (gap) @(negedge clk_sys_i);
    neg_edge_en_o = 1'b1;
    @(negedge clk_sys_i);
    idle();
  end
  endtask
  // Lines start released.
  initial
  begin
    addr_o = 4'h0;
    wr_data_o = 36'h0;
    byte_lane_write_select_n_o = 4'h0;
    idle();
  end
endmodule

// >>> tb/ddr_sram_byte_write_mask_tb.sv
// Self-checking bench for the masked write path in both lane builds.
`timescale 1ns/1ps
module ddr_sram_byte_write_mask_tb;
  logic clk_sys_i, sys_rst_i, pos_en, neg_en, ld_n, rw;
  logic [3:0] addr, sel, rd_addr;
  logic [35:0] wdata, rd_w, exp_w [16];
  logic [17:0] rd_n, exp_n [16];
  logic [1:0] rdy, busy;
  int fails, total_checks, n;
  dbwm_ctrl_model ctrl_u (.clk_sys_i(clk_sys_i), .pos_edge_en_o(pos_en), .neg_edge_en_o(neg_en),
    .load_strobe_n_o(ld_n), .read_write_sel_o(rw), .addr_o(addr), .wr_data_o(wdata),
    .byte_lane_write_select_n_o(sel));
  dbwm_core #(.LANES(4)) dut_u (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .pos_edge_en_i(pos_en), .neg_edge_en_i(neg_en), .load_strobe_n_i(ld_n),
    .read_write_sel_i(rw), .addr_i(addr), .wr_data_i(wdata), .byte_lane_write_select_n_i(sel),
    .rd_addr_i(rd_addr), .rd_data_o(rd_w), .beat_ready_o(rdy[1]), .write_busy_o(busy[1]));
  dbwm_core #(.LANES(2)) dut_n_u (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .pos_edge_en_i(pos_en), .neg_edge_en_i(neg_en), .load_strobe_n_i(ld_n),
    .read_write_sel_i(rw), .addr_i(addr), .wr_data_i(wdata[17:0]),
    .byte_lane_write_select_n_i(sel[1:0]), .rd_addr_i(rd_addr), .rd_data_o(rd_n),
    .beat_ready_o(rdy[0]), .write_busy_o(busy[0]));
  // Free-running system clock.
  initial
  begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  // Verdict and end of run.
  task automatic report_and_stop();
  begin
    if (fails == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask
  task automatic compare_value(input string what, input logic [35:0] exp, input logic [35:0] got);
  begin
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  end
  endtask
  // Reference merge: a lane whose select is low takes the new byte, others keep theirs.
  function automatic logic [35:0] merge(input logic [35:0] old, input logic [35:0] d,
                                        input logic [3:0] s, input int lanes);
  begin
    merge = old;
    for (int i = 0; i < lanes; i++)
      if (!s[i]) merge[i*9 +: 9] = d[i*9 +: 9];
  end
  endfunction
  // Read one word from both builds and compare with the reference.
  task automatic read_check(input logic [3:0] a);
  begin
    rd_addr = a;
    @(negedge clk_sys_i);
    compare_value("wide word", exp_w[a], rd_w);
    compare_value("narrow word", {18'h0, exp_n[a]}, {18'h0, rd_n});
  end
  endtask
  // Burst with random data, reference update, bounded drain wait and readback of both words.
  task automatic wr(input logic [3:0] a, input logic [3:0] s1, input logic [3:0] s2,
                    input logic rd, input int gap);
    logic [35:0] d1, d2;
  begin
    d1 = {4'($urandom()), $urandom()};
    d2 = {4'($urandom()), $urandom()};
    ctrl_u.burst(a, d1, d2, s1, s2, rd, gap);
    // A taken write is still queued here; a read never starts a burst.
    compare_value("busy", rd ? 36'h0 : 36'h3, {34'h0, busy});
    if (!rd)
    begin
      exp_w[a] = merge(exp_w[a], d1, s1, 4);
      exp_w[a ^ 4'h1] = merge(exp_w[a ^ 4'h1], d2, s2, 4);
      exp_n[a] = 18'(merge({18'h0, exp_n[a]}, d1, s1, 2));
      exp_n[a ^ 4'h1] = 18'(merge({18'h0, exp_n[a ^ 4'h1]}, d2, s2, 2));
    end
    for (n = 0; n < 40 && busy !== 2'b00; n++) @(negedge clk_sys_i);
    if (n == 40)
    begin
      fails++;
      report_and_stop();
    end
    read_check(a);
    read_check(a ^ 4'h1);
  end
  endtask
  // Main sequence.
  initial
  begin
    fails = 0;
    total_checks = 0;
    sys_rst_i = 1'b1;
    rd_addr = 4'h0;
    void'($urandom(32'h954a));
    repeat (6) @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    compare_value("ready", 36'h3, {34'h0, rdy});
    // Full-lane writes give every word a known base before partial writes.
    for (int a = 0; a < 16; a += 2) wr(4'(a), 4'h0, 4'h0, 1'b0, a % 3);
    for (int s = 0; s < 16; s++) wr(4'($urandom()), 4'(s), ~4'(s), 1'b0, s % 3);
    for (int s = 15; s >= 0; s--) wr(4'($urandom()), 4'(s), 4'(s), 1'b0, 0);
    wr(4'h5, 4'h0, 4'h0, 1'b1, 1);
    report_and_stop();
  end
endmodule
